/* File: src/trigger_link_encoder.sv */
// Transmit-side encoder: serial command line and 16-bit trigger word stream.
// Assumes one 250 MHz clock; the serializer and delay primitive sit outside.
// Assumes startup_go and trigger_start_go come from logic on this clock.
// Assumes a pad stage turns line and toggle into the Manchester pair.
//
// How it works
// - One command line bit per 4 ns clock
// - Line high over four samples means idle
// - Zero start bit, four bits LSB first
// - One stop bit then line held high
// - Output delay tap setting in 80 ps steps
// - Manchester encode each line bit
// - Before start: refuse triggers, send idle words
// - After start: only valid non-idle words
// - Trigger-start command after programmed delay
// - Clock-reset command aligned to word clock
// - Clock-reset precedes sync by recovery time
// - One 16-bit word every 16 ns
// - Accepted trigger strobe has top priority
// - Strobe carries two-bit quadrant field
// - Content words queued, sent in free slots
// - Control words queued, sent in free slots
// - Time word carries time bits 13:2
// - Word type in bits 15 to 12
// - Strobe A/B action in bits 9:8
// - Partition strobe: four three-bit event fields
// - Main strobe before partition strobe
`include "trigger_link_map.svh"
`timescale 1ns/10ps
`default_nettype none

module trigger_link_encoder #(
    parameter int RECOVERY_CYC = `RECOVERY_US_DEF * 250,
    parameter int START_DELAY  = `START_DELAY_DEF,
    parameter int QDEPTH       = 4
) (
    input  wire logic                         clock,
    input  wire logic                         srst,
    input  wire logic                         startup_go,
    input  wire logic                         trigger_start_go,
    input  wire logic [`DELAY_TAP_W-1:0]      delay_taps_in,
    input  wire logic                         strobe_valid,
    input  wire trigger_link_pkg::strobe_req_t strobe_in,
    output logic                              strobe_ready,
    input  wire logic                         partition_valid,
    input  wire logic [11:0]                  partition_fields,
    output logic                              partition_ready,
    input  wire logic                         content_valid,
    input  wire logic [11:0]                  content_data,
    output logic                              content_ready,
    input  wire logic                         control_valid,
    input  wire logic [11:0]                  control_data,
    output logic                              control_ready,
    output logic [15:0]                       trigger_word,
    output logic                              trigger_word_valid,
    output logic                              word_strobe,
    output logic                              cmd_line_p,
    output logic                              cmd_line_n,
    output logic                              cmd_line_plain,
    output logic [`DELAY_TAP_W-1:0]           delay_taps,
    output logic                              running
);
    import trigger_link_pkg::*;

    // ********************************************************
    // Word clock phase and time counter
    // ********************************************************
    // Phase 3 is the last 4 ns quarter of a word slot; the word register
    // loads on the edge that ends it, so each word stands four cycles.
    // Phase and time share one reset, so time_r[1:0] is 3 at every slot end
    // and bits 13:2 count whole slots since reset.
    // The time counter wraps every 16384 cycles; the far end compares modulo that.

    logic [1:0]  phase_r;
    logic [13:0] time_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            phase_r <= 2'h0;
            time_r  <= 14'h0000;
        end else begin
            phase_r <= phase_r + 2'h1;
            time_r  <= time_r + 14'h0001;
        end
    end
    assign word_strobe = (phase_r == 2'h3);

    // ********************************************************
    // Start-up sequencer
    // ********************************************************
    // Start-up order:
    //   startup_go         -> clock-reset command on a word slot boundary
    //   RECOVERY_CYC wait  -> transceivers at the far end settle
    //   trigger_start_go   -> stream goes live, triggers accepted
    //   START_DELAY wait   -> trigger-start command on the line
    // The recovery wait is counted from the clock-reset launch, so the gap to
    // the trigger-start command is always longer than RECOVERY_CYC.
    // A late trigger_start_go only stretches the idle-word period.

    typedef enum logic [2:0] {
        S_IDLE, S_RESET_SEND, S_RECOVER, S_WAIT_START, S_RUN_DELAY, S_SYNC_SEND, S_RUN
    } seq_t;
    seq_t        seq_r;
    logic [31:0] wait_r;
    logic        cmd_req;
    logic [3:0]  cmd_code;
    logic        cmd_busy;

    always_ff @(posedge clock) begin
        if (srst) begin
            seq_r  <= S_IDLE;
            wait_r <= 32'h0;
        end else begin
            unique case (seq_r)
                S_IDLE:
                    if (startup_go) begin
                        seq_r <= S_RESET_SEND;
                    end
                S_RESET_SEND:
                    // Launch lines up with the word clock boundary
                    if (!cmd_busy && word_strobe) begin
                        seq_r  <= S_RECOVER;
                        wait_r <= 32'h0;
                    end
                S_RECOVER: begin
                    wait_r <= wait_r + 32'h1;
                    if (wait_r >= 32'(RECOVERY_CYC)) begin
                        seq_r <= S_WAIT_START;
                    end
                end
                S_WAIT_START:
                    if (trigger_start_go) begin
                        seq_r  <= S_RUN_DELAY;
                        wait_r <= 32'h0;
                    end
                S_RUN_DELAY: begin
                    wait_r <= wait_r + 32'h1;
                    if (wait_r >= 32'(START_DELAY)) begin
                        seq_r <= S_SYNC_SEND;
                    end
                end
                S_SYNC_SEND:
                    if (!cmd_busy) begin
                        seq_r <= S_RUN;
                    end
                S_RUN: ;
            endcase
        end
    end

    // ********************************************************
    // Command launch
    // ********************************************************
    assign cmd_req  = (seq_r == S_RESET_SEND && word_strobe) || (seq_r == S_SYNC_SEND);
    assign cmd_code = (seq_r == S_RESET_SEND) ? `CMD_CLOCK_RESET : `CMD_TRIGGER_START;
    // Stream starts with the delay period, not after the command
    assign running  = (seq_r == S_RUN_DELAY) || (seq_r == S_SYNC_SEND) || (seq_r == S_RUN);

    // ********************************************************
    // Serial command line
    // ********************************************************
    // Frame: start, 4 data, stop, then idle ones; 11 bit times total
    // Edges counted from the launch edge:
    //   edge 0       line low, start bit
    //   edges 1-4    command bits, least significant first
    //   edges 5-10   line high, stop bit then five idle samples
    //   edge 11      counter empty, next launch allowed
    // Six high samples always follow, so a receiver never misses the idle gap.
    logic [3:0] bit_cnt_r;
    logic [3:0] cmd_sh_r;
    logic       line_r;
    logic       half_r;

    // Busy also gates the sequencer, so a pending request simply waits
    assign cmd_busy = (bit_cnt_r != 4'h0);

    always_ff @(posedge clock) begin
        if (srst) begin
            bit_cnt_r <= 4'h0;
            cmd_sh_r  <= 4'h0;
            line_r    <= 1'b1;
        end else if (cmd_busy) begin
            bit_cnt_r <= bit_cnt_r - 4'h1;
            if (bit_cnt_r > 4'h6) begin
                line_r   <= cmd_sh_r[0];
                cmd_sh_r <= {1'b0, cmd_sh_r[3:1]};
            end else begin
                line_r <= 1'b1;
            end
        end else if (cmd_req) begin
            bit_cnt_r <= 4'hA;
            cmd_sh_r  <= cmd_code;
            line_r    <= 1'b0;
        end
    end

    // ********************************************************
    // Line code and output delay
    // ********************************************************

    // The toggle stands in for the half-bit clock; the pad doubles the rate,
    // so only the phase relation of line and toggle matters here.
    // Half-bit phase toggles each edge; the output pad runs it at double rate
    always_ff @(posedge clock) begin
        if (srst) begin
            half_r <= 1'b0;
        end else begin
            half_r <= ~half_r;
        end
    end
    assign cmd_line_plain = line_r;
    assign cmd_line_p     = line_r ^ half_r;
    assign cmd_line_n     = ~(line_r ^ half_r);

    // Taps are only registered; the delay element itself sits in the pad ring
    always_ff @(posedge clock) begin
        if (srst) begin
            delay_taps <= '0;
        end else begin
            delay_taps <= delay_taps_in;
        end
    end

    // ********************************************************
    // Word queues for content and control
    // ********************************************************
    // Pointers carry one extra bit so that full and empty differ when the
    // low bits match. Storage has no reset; only pointers decide what is live.
    // Index 0 is the content queue, index 1 the control queue.
    // Ready is plain not-full: a push into a full queue is refused even when
    // a pop falls in the same cycle, which keeps ready free of pop logic.
    // AW must be at least one, so QDEPTH is at least two.
    localparam int AW = $clog2(QDEPTH);
    logic [11:0]  q_mem [2][QDEPTH];
    logic [AW:0]  q_wp_r [2];
    logic [AW:0]  q_rp_r [2];
    logic [1:0]   q_push;
    logic [1:0]   q_pop;
    logic [1:0]   q_empty;
    logic [1:0]   q_full;
    logic [11:0]  q_din [2];

    assign q_din[0] = content_data;
    assign q_din[1] = control_data;
    assign q_push   = {control_valid & ~q_full[1], content_valid & ~q_full[0]};
    assign content_ready = ~q_full[0];
    assign control_ready = ~q_full[1];

    for (genvar g = 0; g < 2; g++) begin : g_q
        assign q_empty[g] = (q_wp_r[g] == q_rp_r[g]);
        assign q_full[g]  = (q_wp_r[g][AW-1:0] == q_rp_r[g][AW-1:0]) &&
                            (q_wp_r[g][AW] != q_rp_r[g][AW]);
        always_ff @(posedge clock) begin
            if (srst) begin
                q_wp_r[g] <= '0;
                q_rp_r[g] <= '0;
            end else begin
                if (q_push[g]) begin
                    q_mem[g][q_wp_r[g][AW-1:0]] <= q_din[g];
                    q_wp_r[g] <= q_wp_r[g] + 1'b1;
                end
                if (q_pop[g]) begin
                    q_rp_r[g] <= q_rp_r[g] + 1'b1;
                end
            end
        end
    end

    // ********************************************************
    // Word selection per 16 ns slot
    // ********************************************************
    // Priority in one slot, highest first:
    //   accepted trigger strobe
    //   partition strobe
    //   content word from its queue
    //   control word from its queue
    //   time word, which keeps the link busy with predictable data
    // The choice is made every cycle but only the slot end loads it.
    logic [15:0] word_nxt;

    always_comb begin
        word_nxt = {`WTYPE_TIME, time_r[13:2]};
        q_pop    = 2'b00;
        if (strobe_valid) begin
            // Type codes 2 and 3 both select the legacy host strobe
            unique case (strobe_in.strobe_type)
                STROBE_A:    word_nxt[15:12] = `WTYPE_STROBE_A;
                STROBE_B:    word_nxt[15:12] = `WTYPE_STROBE_B;
                default:     word_nxt[15:12] = `WTYPE_HOST_STROBE;
            endcase
            word_nxt[11:10] = strobe_in.quadrant;
            word_nxt[9:8]   = strobe_in.action;
            word_nxt[7:0]   = {2'b00, strobe_in.event_type};
        end else if (partition_valid) begin
            word_nxt = {`WTYPE_PARTITION, partition_fields};
        end else if (!q_empty[0]) begin
            q_pop[0] = word_strobe && running;
            word_nxt = {`WTYPE_CONTENT, q_mem[0][q_rp_r[0][AW-1:0]]};
        end else if (!q_empty[1]) begin
            q_pop[1] = word_strobe && running;
            word_nxt = {`WTYPE_CONTROL, q_mem[1][q_rp_r[1][AW-1:0]]};
        end
        if (!(word_strobe && running)) begin
            q_pop = 2'b00;
        end
    end

    // ********************************************************
    // Trigger acceptance
    // ********************************************************
    // Ready depends only on slot, run state and, for partitions, strobe_valid, never on its own valid, so a
    // source may hold a request across slots without a combinational loop.
    // Triggers are refused until the stream runs
    assign strobe_ready    = running && word_strobe;
    assign partition_ready = running && word_strobe && !strobe_valid;

    // ********************************************************
    // Trigger word output
    // ********************************************************
    // Idle words go out with valid low, so far-end queues stay empty
    always_ff @(posedge clock) begin
        if (srst) begin
            trigger_word       <= `IDLE_WORD;
            trigger_word_valid <= 1'b0;
        end else if (word_strobe) begin
            if (running) begin
                trigger_word       <= word_nxt;
                trigger_word_valid <= 1'b1;
            end else begin
                trigger_word       <= `IDLE_WORD;
                trigger_word_valid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

/* File: src/trigger_link_map.svh */
// Constants for the trigger link encoder: word codes, command codes, timing counts.
// Assumes a 250 MHz master clock; counts are in master clock cycles, RECOVERY_US_DEF in microseconds.
`ifndef TRIGGER_LINK_MAP_SVH
`define TRIGGER_LINK_MAP_SVH

`define CLK_PERIOD_PS       4000
`define CMD_BIT_NS          4
`define CMD_BIT_CYC         ((`CMD_BIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define WORD_NS             16
`define WORD_CYC            ((`WORD_NS * 1000) / `CLK_PERIOD_PS)
`define IDLE_MIN_SAMPLES    4
`define DELAY_STEP_PS       80
`define DELAY_TAP_W         6

`define WTYPE_TIME          4'h4
`define WTYPE_CONTROL       4'h5
`define WTYPE_HOST_STROBE   4'h6
`define WTYPE_CONTENT       4'h7
`define WTYPE_STROBE_A      4'h9
`define WTYPE_STROBE_B      4'hA
`define WTYPE_PARTITION     4'hB

`define CMD_CLOCK_RESET     4'h1
`define CMD_TRIGGER_START   4'h2

`define IDLE_WORD           16'h0000
`define RECOVERY_US_DEF     5000
`define START_DELAY_DEF     1000

`endif

/* File: src/trigger_link_pkg.sv */
// Types shared by the trigger link encoder.
// Assumes nothing beyond the constants header.
package trigger_link_pkg;

    typedef struct packed {
        logic [1:0] strobe_type;
        logic [1:0] action;
        logic [5:0] event_type;
        logic [1:0] quadrant;
    } strobe_req_t;

    typedef enum logic [1:0] {
        STROBE_A    = 2'h0,
        STROBE_B    = 2'h1,
        STROBE_HOST = 2'h2
    } strobe_kind_t;

endpackage

/* File: tb/trigger_link_chk.sv */
// Port checker for the trigger link encoder.
// Assumes the bind at the foot reaches every encoder instance.
`include "trigger_link_map.svh"
`timescale 1ns/10ps
`default_nettype none

module trigger_link_chk (
    input wire logic                          clock,
    input wire logic                          srst,
    input wire logic [`DELAY_TAP_W-1:0]       delay_taps_in,
    input wire logic                          strobe_valid,
    input wire trigger_link_pkg::strobe_req_t strobe_in,
    input wire logic                          strobe_ready,
    input wire logic                          partition_valid,
    input wire logic [11:0]                   partition_fields,
    input wire logic                          partition_ready,
    input wire logic [15:0]                   trigger_word,
    input wire logic                          trigger_word_valid,
    input wire logic                          word_strobe,
    input wire logic                          cmd_line_p,
    input wire logic                          cmd_line_n,
    input wire logic                          cmd_line_plain,
    input wire logic [`DELAY_TAP_W-1:0]       delay_taps,
    input wire logic                          running
);
    import trigger_link_pkg::*;
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    logic [2:0] idle_r;
    wire        tgl = cmd_line_p ^ cmd_line_plain;
    // Line counts as idle out of reset, so a command may start at once
    always_ff @(posedge clock) begin
        if (srst) idle_r <= 3'h5;
        else if (!cmd_line_plain) idle_r <= 3'h0;
        else if (idle_r != 3'h7) idle_r <= idle_r + 3'h1;
    end
    function automatic logic [3:0] kind(input logic [1:0] k);
        return k == 2'h0 ? `WTYPE_STROBE_A : k == 2'h1 ? `WTYPE_STROBE_B : `WTYPE_HOST_STROBE;
    endfunction
    sequence cmd_start;
        !cmd_line_plain && idle_r > 3'h4;
    endsequence
    sequence stop_idle;
        cmd_line_plain [*6];
    endsequence
    chk_frame_shape: assert property (cmd_start |-> ##5 stop_idle)
        else $error("command frame not closed by stop and idle");
    chk_slot_period: assert property (word_strobe |=> !word_strobe [*3] ##1 word_strobe)
        else $error("word slot not one in four cycles");
    chk_word_holds: assert property (!$past(word_strobe) |-> $stable(trigger_word))
        else $error("word changed outside slot end");
    chk_idle_prestart: assert property (!running |-> trigger_word == `IDLE_WORD && !trigger_word_valid)
        else $error("non-idle word before start");
    chk_live_typed: assert property (trigger_word_valid |->
        trigger_word[15:12] inside {4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hA, 4'hB})
        else $error("valid word with unknown type");
    chk_strobe_gate: assert property (strobe_ready |-> running && word_strobe)
        else $error("strobe accepted outside live slot");
    chk_strobe_word: assert property (strobe_valid && strobe_ready |=> trigger_word ==
        {kind($past(strobe_in.strobe_type)), $past(strobe_in.quadrant), $past(strobe_in.action),
         2'h0, $past(strobe_in.event_type)})
        else $error("strobe word wrong");
    chk_part_yield: assert property (partition_ready |-> running && word_strobe && !strobe_valid)
        else $error("partition strobe not yielding");
    chk_part_word: assert property (partition_valid && partition_ready |=>
        trigger_word == {`WTYPE_PARTITION, $past(partition_fields)})
        else $error("partition word wrong");
    chk_pair_diff: assert property (cmd_line_n == !cmd_line_p)
        else $error("command pair not complementary");
    chk_half_toggle: assert property (!$past(srst) |-> tgl != $past(tgl))
        else $error("line code not toggling");
    chk_taps_follow: assert property (!srst |=> delay_taps == $past(delay_taps_in))
        else $error("delay taps not following");
endmodule

bind trigger_link_encoder trigger_link_chk chk_i (.clock, .srst, .delay_taps_in, .strobe_valid,
    .strobe_in, .strobe_ready, .partition_valid, .partition_fields, .partition_ready,
    .trigger_word, .trigger_word_valid, .word_strobe, .cmd_line_p, .cmd_line_n,
    .cmd_line_plain, .delay_taps, .running);
`default_nettype wire

/* File: tb/trigger_rx_model.sv */
// Receiver board model: command line decoder and fixed latency FIFO count.
// Assumes the plain command line and the word stream share one clock.
`timescale 1ns/10ps
`default_nettype none

module trigger_rx_model (
    input  wire logic  clock,
    input  wire logic  srst,
    input  wire logic  line,
    input  wire logic  word_strobe,
    input  wire logic  word_valid,
    output logic       cmd_done,
    output logic [3:0] cmd_code,
    output logic       cmd_aligned,
    output logic       reads_on,
    output int         fifo_words
);
    int   ones;
    int   pos;
    logic ws_d;
    always @(posedge clock) begin
        cmd_done <= 1'b0;
        ws_d <= word_strobe;
        if (srst) begin
            ones <= 5;
            pos <= 0;
            reads_on <= 1'b0;
            fifo_words <= 0;
        end else begin
            ones <= (line && pos == 0) ? ones + 1 : 0;
            if (pos == 0 && !line && ones > 4) begin
                pos <= 1;
                cmd_aligned <= ws_d;
            end else if (pos > 0) begin
                cmd_code[pos-1] <= line;
                pos <= (pos == 4) ? 0 : pos + 1;
                cmd_done <= (pos == 4);
            end
            // Only valid words enter; reads start at trigger start
            if (cmd_done && cmd_code == 4'h2) begin
                reads_on <= 1'b1;
                fifo_words <= 0;
            end else if (word_strobe) begin
                fifo_words <= fifo_words + int'(word_valid) - int'(reads_on);
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/trigger_link_encoder_bench.sv */
// Self-checking bench for the trigger link encoder with a queue model.
// Assumes shortened recovery and start delays set below.
`include "trigger_link_map.svh"
`timescale 1ns/10ps
`default_nettype none

module trigger_link_encoder_bench;
    import trigger_link_pkg::*;
    localparam int QD = 4;
    localparam int RCY = 50;
    localparam int SDL = 20;
    logic clock = 1'b0, srst = 1'b1, startup_go = 1'b0, trigger_start_go = 1'b0;
    logic strobe_valid = 1'b0, partition_valid = 1'b0, content_valid = 1'b0;
    logic control_valid = 1'b0, pend = 1'b0, exp_valid;
    logic s_keep = 1'b0, p_keep = 1'b0, c_keep = 1'b0, k_keep = 1'b0;
    logic [5:0]  delay_taps_in = 6'h00;
    logic [11:0] partition_fields = 12'h000, content_data = 12'h000, control_data = 12'h000;
    strobe_req_t strobe_in = '0;
    logic strobe_ready, partition_ready, content_ready, control_ready, trigger_word_valid;
    logic word_strobe, cmd_line_p, cmd_line_n, cmd_line_plain, running, cmd_done;
    logic cmd_aligned, reads_on;
    logic [3:0]  cmd_code;
    logic [5:0]  delay_taps;
    logic [15:0] trigger_word, exp_word;
    logic [11:0] cq[$], kq[$];
    logic [3:0]  codes[$];
    logic        al[$];
    int when[$];
    int failures = 0, samples_checked = 0, seed = 32'hA1E0, slot = 0, cyc = 0, t_run = 0;
    int rx_words;

    trigger_link_encoder #(.RECOVERY_CYC(RCY), .START_DELAY(SDL), .QDEPTH(QD)) DUT (.clock, .srst,
        .startup_go, .trigger_start_go, .delay_taps_in, .strobe_valid, .strobe_in, .strobe_ready,
        .partition_valid, .partition_fields, .partition_ready, .content_valid, .content_data,
        .content_ready, .control_valid, .control_data, .control_ready, .trigger_word,
        .trigger_word_valid, .word_strobe, .cmd_line_p, .cmd_line_n, .cmd_line_plain,
        .delay_taps, .running);
    trigger_rx_model rx (.clock, .srst, .line(cmd_line_plain), .word_strobe,
        .word_valid(trigger_word_valid), .cmd_done, .cmd_code, .cmd_aligned, .reads_on,
        .fifo_words(rx_words));

    // ************************************************************
    // Checking and stimulus
    // ************************************************************
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        if (cmd_done) begin
            codes.push_back(cmd_code);
            al.push_back(cmd_aligned);
            when.push_back(cyc);
        end
    end
    function automatic logic [3:0] kind(input logic [1:0] k);
        return k == 2'h0 ? `WTYPE_STROBE_A : k == 2'h1 ? `WTYPE_STROBE_B : `WTYPE_HOST_STROBE;
    endfunction
    task automatic check_val(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_span(input string what, input int e, input int g);
        samples_checked++;
        if (g != e) begin
            failures++;
            $display("Error %s expected %0d seen %0d", what, e, g);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Mode 0 idle, 1 all sources random, 2 strobes only so the queues drain
    task automatic step(input int mode);
        logic [31:0] r;
        logic [31:0] u;
        logic        ok_c, ok_k;
        @(negedge clock);
        cyc++;
        if (pend) check_val("trigger_word", exp_word, trigger_word);
        if (pend) check_val("word_valid", {15'h0, exp_valid}, {15'h0, trigger_word_valid});
        pend = 1'b0;
        r = $random(seed);
        u = $random(seed);
        // A refused request keeps its value until the edge that takes it
        if (!s_keep) begin
            strobe_valid = mode != 0 && r[1:0] == 2'h0 && word_strobe === 1'b1;
            strobe_in = r[15:4];
        end
        if (!p_keep) begin
            partition_valid = mode != 0 && r[2] && r[28] && word_strobe === 1'b1;
            partition_fields = r[27:16];
        end
        if (!c_keep) begin
            content_valid = mode == 1 && r[3];
            content_data = u[11:0];
        end
        if (!k_keep) begin
            control_valid = mode == 1 && r[4];
            control_data = u[23:12];
        end
        delay_taps_in = u[29:24];
        #1;
        ok_c = cq.size() < QD;
        ok_k = kq.size() < QD;
        check_val("content_ready", {15'h0, ok_c}, {15'h0, content_ready});
        check_val("control_ready", {15'h0, ok_k}, {15'h0, control_ready});
        if (running === 1'b1 && t_run == 0) t_run = cyc;
        if (word_strobe === 1'b1) begin
            pend = 1'b1;
            exp_valid = running;
            if (running !== 1'b1) exp_word = `IDLE_WORD;
            else if (strobe_valid) exp_word = {kind(strobe_in.strobe_type), strobe_in.quadrant,
                strobe_in.action, 2'h0, strobe_in.event_type};
            else if (partition_valid) exp_word = {`WTYPE_PARTITION, partition_fields};
            else if (cq.size() > 0) exp_word = {`WTYPE_CONTENT, cq.pop_front()};
            else if (kq.size() > 0) exp_word = {`WTYPE_CONTROL, kq.pop_front()};
            else exp_word = {`WTYPE_TIME, slot[11:0]};
            slot++;
        end
        s_keep = strobe_valid && strobe_ready !== 1'b1;
        p_keep = partition_valid && partition_ready !== 1'b1;
        c_keep = content_valid && !ok_c;
        k_keep = control_valid && !ok_k;
        if (content_valid && ok_c) cq.push_back(content_data);
        if (control_valid && ok_k) kq.push_back(control_data);
    endtask

    initial begin
        repeat (3) @(negedge clock);
        srst = 1'b0;
        repeat (16) step(2);
        startup_go = 1'b1;
        trigger_start_go = 1'b1;
        for (int i = 0; i < 400 && running !== 1'b1; i++) step(2);
        check_span("fifo_prestart", 0, rx_words);
        repeat (200) step(1);
        repeat (120) step(2);
        repeat (20) step(0);
        check_span("commands", 2, codes.size());
        if (codes.size() == 2) begin
            check_val("first_code", `CMD_CLOCK_RESET, codes[0]);
            check_val("aligned", 16'h0001, al[0]);
            check_val("second_code", `CMD_TRIGGER_START, codes[1]);
            check_span("recovery", 1, int'(when[1] - when[0] >= RCY));
            check_span("start_delay", 1, int'(when[1] - t_run inside {[20:40]}));
        end
        check_val("reads_on", 16'h0001, reads_on);
        check_span("fifo_level", 0, rx_words);
        finish_test();
    end
    initial begin
        #50000;
        failures++;
        finish_test();
    end
endmodule
`default_nettype wire
